// *** core/albe_alu.sv ***
// combinational decode and arithmetic for the four instructions
`timescale 1ns/10ps
module albe_alu
  import albe_pkg::*;
(
  albe_alu_if.alu p  // operand and result bundle
);

  logic [8:0] sum9;
  logic [4:0] low5;

  assign sum9 = {1'b0, p.acc} + {1'b0, p.fval};
  assign low5 = {1'b0, p.acc[3:0]} + {1'b0, p.fval[3:0]};

  always_comb
  begin
    p.op      = ALBE_OP_NONE;
    p.res     = 8'h00;
    p.wr_acc  = 1'b0;
    p.wr_file = 1'b0;
    p.upd_c   = 1'b0;
    p.upd_hbo = 1'b0;
    p.upd_z   = 1'b0;
    p.c       = sum9[8];
    p.hbo     = low5[4];
    if (p.instr[11:6] == OPC_SUM)
    begin
      p.op      = ALBE_OP_SUM;
      p.res     = sum9[7:0];
      p.upd_c   = 1'b1;
      p.upd_hbo = 1'b1;
      p.upd_z   = 1'b1;
      p.wr_acc  = !p.instr[DEST_BIT];
      p.wr_file = p.instr[DEST_BIT];
    end
    else if (p.instr[11:6] == OPC_ANDF)
    begin
      p.op      = ALBE_OP_ANDF;
      p.res     = p.acc & p.fval;
      p.upd_z   = 1'b1;
      p.wr_acc  = !p.instr[DEST_BIT];
      p.wr_file = p.instr[DEST_BIT];
    end
    else if (p.instr[11:8] == OPC_ANDL)
    begin
      p.op      = ALBE_OP_ANDL;
      p.res     = p.acc & p.instr[7:0];
      p.upd_z   = 1'b1;
      p.wr_acc  = 1'b1;
    end
    else if (p.instr[11:8] == OPC_BCLR)
    begin
      p.op      = ALBE_OP_BCLR;
      p.res     = p.fval & ~(8'h01 << p.instr[7:5]);
      p.wr_file = 1'b1;
    end
    p.z = (p.res == 8'h00);
  end

endmodule : albe_alu

// *** core/albe_alu_if.sv ***
// signals between the bus top and the arithmetic unit
`timescale 1ns/10ps
interface albe_alu_if;
  import albe_pkg::*;
  logic [INSTR_W-1:0] instr;   // instruction word
  logic [7:0]         acc;     // accumulator value
  logic [7:0]         fval;    // indexed file register value
  albe_op_t           op;      // decoded operation
  logic [7:0]         res;     // result
  logic               wr_acc;  // result goes to accumulator
  logic               wr_file; // result goes to file register
  logic               upd_c;   // carry updated
  logic               upd_hbo; // half-byte flag updated
  logic               upd_z;   // zero flag updated
  logic               c;       // new carry
  logic               hbo;     // new half-byte overflow
  logic               z;       // new zero

  modport top (output instr, acc, fval,
               input  op, res, wr_acc, wr_file, upd_c, upd_hbo, upd_z, c, hbo, z);
  modport alu (input  instr, acc, fval,
               output op, res, wr_acc, wr_file, upd_c, upd_hbo, upd_z, c, hbo, z);
endinterface : albe_alu_if

// *** core/albe_pkg.sv ***
// shared constants and types for the accumulator execution block
package albe_pkg;

  localparam int        DATA_W     = 8;
  localparam int        NREGS      = 32;
  localparam int        IDX_W      = 5;
  localparam int        INSTR_W    = 12;

  // register byte offsets in the 8-bit decode window
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_ACC    = 8'h04;
  localparam logic [7:0] OFF_FLAGS  = 8'h08;
  localparam logic [7:0] OFF_ISTAT  = 8'h0c;
  localparam logic [7:0] OFF_IMASK  = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;
  localparam logic [7:0] OFF_LASTOP = 8'h18;
  localparam logic [7:0] OFF_FILE   = 8'h80;

  // opcode patterns
  localparam logic [5:0] OPC_SUM    = 6'h07;
  localparam logic [5:0] OPC_ANDF   = 6'h05;
  localparam logic [3:0] OPC_ANDL   = 4'he;
  localparam logic [3:0] OPC_BCLR   = 4'h4;
  localparam int         DEST_BIT   = 5;

  // flag register layout
  localparam int        FLG_CARRY  = 0;
  localparam int        FLG_HBO    = 1;
  localparam int        FLG_ZERO   = 2;
  localparam int        FLG_W      = 3;

  // interrupt layout
  localparam int        IRQ_DONE   = 0;
  localparam int        IRQ_BAD    = 1;
  localparam int        IRQ_W      = 2;

  // reset values
  localparam logic [7:0]         RST_ACC   = 8'h00;
  localparam logic [FLG_W-1:0]   RST_FLAGS = 3'h0;
  localparam logic [IRQ_W-1:0]   RST_IMASK = 2'h0;
  localparam logic [INSTR_W-1:0] RST_INSTR = 12'h000;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [2:0]
  {
    ALBE_OP_NONE,
    ALBE_OP_SUM,
    ALBE_OP_ANDF,
    ALBE_OP_ANDL,
    ALBE_OP_BCLR
  } albe_op_t;

endpackage : albe_pkg

// *** core/albe_top.sv ***
// AHB-Lite slave wrapping the accumulator, file registers and execution unit
//
// Overview of operation
// - sum opcode adds accumulator and indexed register, updating carry, half-byte, zero.
// - destination bit zero sends result to accumulator, source register untouched.
// - destination bit one writes result back into the indexed source register.
// - register AND opcode ANDs accumulator with register, updates only zero flag.
// - literal AND opcode ANDs accumulator with low eight bits, zero flag only.
// - literal AND result always lands in the accumulator.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module albe_top
  import albe_pkg::*;
(
  input  wire logic        hclk,       // bus clock
  input  wire logic        hresetn,    // async reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write when high
  input  wire logic [2:0]  hsize,      // transfer size
  input  wire logic        hready,     // bus ready in
  input  wire logic [31:0] hwdata,     // write data
  output logic             hreadyout,  // slave ready
  output logic             hresp,      // response
  output logic [31:0]      hrdata,     // read data
  output logic             irq         // interrupt level
);

  logic [7:0]         freg_r [NREGS];
  logic [7:0]         acc_r;
  logic [FLG_W-1:0]   flags_r;
  logic [IRQ_W-1:0]   istat_r;
  logic [IRQ_W-1:0]   istat_nxt;
  logic [IRQ_W-1:0]   imask_r;
  logic [7:0]         result_r;
  logic [INSTR_W-1:0] lastop_r;
  logic               wr_pend_r;
  logic [7:0]         waddr_r;
  logic               hreadyout_r;
  logic [31:0]        hrdata_r;
  logic               irq_r;
  logic               addr_ok;
  logic               exec;
  logic               wr_acc_bus;
  logic               wr_flags_bus;
  logic               wr_file_bus;
  logic [IRQ_W-1:0]   ev_set;
  logic [IRQ_W-1:0]   ev_clr;

  albe_alu_if alu_bus ();

  albe_alu u_alu
  (
    .p (alu_bus.alu)
  );

  // file register index from a byte offset
  function automatic logic [IDX_W-1:0] file_idx(input logic [7:0] a);
    file_idx = a[IDX_W+1:2];
  endfunction : file_idx

  // read data for an address phase
  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h0000_0000;
    if (a[7])
      read_word = {24'h00_0000, freg_r[file_idx(a)]};
    else
      case (a)
        OFF_INSTR:  read_word = {20'h0_0000, lastop_r};
        OFF_ACC:    read_word = {24'h00_0000, acc_r};
        OFF_FLAGS:  read_word = {29'h0000_0000, flags_r};
        OFF_ISTAT:  read_word = {30'h0000_0000, istat_r};
        OFF_IMASK:  read_word = {30'h0000_0000, imask_r};
        OFF_RESULT: read_word = {24'h00_0000, result_r};
        OFF_LASTOP: read_word = {29'h0000_0000, alu_bus.op};
        default:    read_word = 32'h0000_0000;
      endcase
  endfunction : read_word

  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

  // operands come straight from the instruction in the data phase
  assign alu_bus.instr = exec ? hwdata[INSTR_W-1:0] : lastop_r;
  assign alu_bus.acc   = acc_r;
  assign alu_bus.fval  = freg_r[alu_bus.instr[IDX_W-1:0]];

  assign exec         = wr_pend_r && (waddr_r == OFF_INSTR);
  assign wr_acc_bus   = wr_pend_r && (waddr_r == OFF_ACC);
  assign wr_flags_bus = wr_pend_r && (waddr_r == OFF_FLAGS);
  assign wr_file_bus  = wr_pend_r && waddr_r[7];

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok)
        waddr_r <= haddr[7:0];
    end
  end

  // zero-wait answer, read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h0000_0000;
    end
    else
    begin
      hreadyout_r <= 1'b1;
      if (addr_ok && !hwrite)
        hrdata_r <= read_word(haddr[7:0]);
    end
  end

  // accumulator
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_r <= RST_ACC;
    else if (wr_acc_bus)
      acc_r <= hwdata[7:0];
    else if (exec && alu_bus.wr_acc)
      acc_r <= alu_bus.res;
  end

  // file registers; source kept unless the result targets it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NREGS; i++)
        freg_r[i] <= 8'h00;
    end
    else if (wr_file_bus)
      freg_r[file_idx(waddr_r)] <= hwdata[7:0];
    else if (exec && alu_bus.wr_file)
      freg_r[alu_bus.instr[IDX_W-1:0]] <= alu_bus.res;
  end

  // status flags, each only when its operation updates it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_r <= RST_FLAGS;
    else if (wr_flags_bus)
      flags_r <= hwdata[FLG_W-1:0];
    else if (exec)
    begin
      if (alu_bus.upd_c)
        flags_r[FLG_CARRY] <= alu_bus.c;
      if (alu_bus.upd_hbo)
        flags_r[FLG_HBO] <= alu_bus.hbo;
      if (alu_bus.upd_z)
        flags_r[FLG_ZERO] <= alu_bus.z;
    end
  end

  // last instruction and result
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lastop_r <= RST_INSTR;
      result_r <= 8'h00;
    end
    else if (exec)
    begin
      lastop_r <= hwdata[INSTR_W-1:0];
      result_r <= alu_bus.res;
    end
  end

  // interrupt status, set beats write-one-to-clear
  always_comb
  begin
    ev_set = '0;
    ev_clr = '0;
    ev_set[IRQ_DONE] = exec && (alu_bus.op != ALBE_OP_NONE);
    ev_set[IRQ_BAD]  = exec && (alu_bus.op == ALBE_OP_NONE);
    if (wr_pend_r && (waddr_r == OFF_ISTAT))
      ev_clr = hwdata[IRQ_W-1:0];
    istat_nxt = (istat_r & ~ev_clr) | ev_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      istat_r <= '0;
    else
      istat_r <= istat_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      imask_r <= RST_IMASK;
    else if (wr_pend_r && (waddr_r == OFF_IMASK))
      imask_r <= hwdata[IRQ_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(istat_nxt & imask_r);
  end

  assign hreadyout = hreadyout_r;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_r;
  assign irq       = irq_r;

endmodule : albe_top

// *** test/albe_checker.sv ***
// bus-side assertions for the execution block
`timescale 1ns/10ps
module albe_checker
  import albe_pkg::*;
(
  input wire logic        hclk,      // clock
  input wire logic        hresetn,   // reset, active low
  input wire logic        hsel,      // select
  input wire logic [31:0] haddr,     // address
  input wire logic [1:0]  htrans,    // transfer type
  input wire logic        hwrite,    // write
  input wire logic [2:0]  hsize,     // size
  input wire logic        hreadyout, // ready
  input wire logic        hresp,     // response
  input wire logic [31:0] hrdata,    // read data
  input wire logic        irq        // interrupt
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  assign rd_take = hsel && hreadyout && htrans == HTRANS_NONSEQ && !hwrite && hsize == HSIZE_WORD;

  AST_READY: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("ready low or error response");
  AST_RD_HOLD: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (rd_take && haddr[7:0] inside {[8'h1c:8'h7c]} |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER: assert property (rd_take |=> hrdata[31:12] == 20'h0)
    else $error("upper read bits set");
  AST_BYTE: assert property (rd_take && haddr[7:0] != OFF_INSTR |=> hrdata[31:8] == 24'h0)
    else $error("byte register wider than eight bits");
  AST_FLAGS: assert property (rd_take && haddr[7:0] == OFF_FLAGS |=> hrdata[31:3] == 29'h0)
    else $error("flag read has stray bits");
  AST_LASTOP: assert property (rd_take && haddr[7:0] == OFF_LASTOP |=> hrdata < 32'h5)
    else $error("decoded op out of range");
endmodule : albe_checker

bind albe_top albe_checker i_albe_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .irq(irq));

// *** test/albe_host.sv ***
// bus master standing in for the instruction decoder
`timescale 1ns/10ps
module albe_host
  import albe_pkg::*;
(
  input  wire logic        hclk,   // clock
  input  wire logic        hready, // bus ready
  output logic [31:0]      haddr,  // address
  output logic [1:0]       htrans, // transfer type
  output logic             hwrite, // write
  output logic [31:0]      hwdata, // write data
  output logic             stuck   // a wait ran out
);
  initial
  begin
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    stuck = 1'b0;
  end
  // one single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk) k++; while (!hready && k < 40);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk) k++; while (!hready && k < 40);
    if (k >= 40) stuck <= 1'b1;
  endtask : xfer
endmodule : albe_host

// *** test/albe_tb_top.sv ***
// self-checking bench for the execution block
`timescale 1ns/10ps
module albe_tb_top;
  import albe_pkg::*;
  logic        hclk, hresetn, hreadyout, hresp, irq, stuck, hwrite, rd_ph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [31:0] expq[$];
  int          n_fail, n_compared;

  albe_top i_albe_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
  albe_host i_albe_host (.hclk(hclk), .hready(hreadyout), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .stuck(stuck));

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task chk(string n, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    i_albe_host.xfer(1'b0, a, 32'h0);
  endtask : rd
  task wr(logic [7:0] a, logic [31:0] d);
    i_albe_host.xfer(1'b1, a, d);
  endtask : wr
  // preload operands, execute one instruction, read back state
  task automatic run(int k, logic d, int i);
    logic [7:0]  a, b, lit, r, fa;
    logic [8:0]  s;
    logic [4:0]  f;
    logic [2:0]  bt, fl, nf;
    logic [11:0] ins;
    logic        df;
    a = $urandom;
    b = (i % 8 == 0) ? -a : $urandom;
    lit = $urandom;
    f = $urandom;
    bt = $urandom;
    fl = $urandom;
    s = {1'b0, a} + {1'b0, b};
    r = k == 0 ? s[7:0] : k == 1 ? a & b : k == 2 ? a & lit : b & ~(8'h1 << bt);
    ins = k == 0 ? {OPC_SUM, d, f} : k == 1 ? {OPC_ANDF, d, f} : k == 2 ? {OPC_ANDL, lit}
        : {OPC_BCLR, bt, f};
    nf = k == 3 ? fl : k == 0 ? {r == 8'h0, a[3:0] + b[3:0] > 5'hf, s[8]} : {r == 8'h0, fl[1:0]};
    df = (k < 2 && d) || k == 3;
    fa = OFF_FILE + {1'b0, f, 2'b00};
    wr(OFF_ACC, a);
    wr(fa, b);
    wr(OFF_FLAGS, fl);
    wr(OFF_INSTR, ins);
    rd(OFF_ACC, df ? a : r);
    rd(fa, df ? r : b);
    rd(OFF_FLAGS, nf);
  endtask : run

  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout) chk("hrdata", hrdata, expq.pop_front());
    rd_ph <= hresetn && htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
    if (stuck)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    rd_ph = 1'b0;
    hresetn = 1'b0;
    void'($urandom(15470));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFF_ACC, 0);
    rd(OFF_FLAGS, 0);
    rd(OFF_IMASK, 0);
    rd(OFF_INSTR, 0);
    rd(8'h40, 0);
    for (int i = 0; i < 24; i++) run(i % 4, i[2] ^ i[3], i);
    wr(OFF_ISTAT, 3);
    rd(OFF_ISTAT, 0);
    wr(OFF_INSTR, 12'he00);
    rd(OFF_ISTAT, 1);
    chk("irq", irq, 0);
    wr(OFF_IMASK, 1);
    repeat (2) @(posedge hclk);
    chk("irq", irq, 1);
    wr(OFF_INSTR, 12'h000);
    rd(OFF_ISTAT, 3);
    rd(OFF_LASTOP, 0);
    rd(OFF_ACC, 0);
    wr(OFF_ISTAT, 1);
    rd(OFF_ISTAT, 2);
    chk("irq", irq, 0);
    repeat (2) @(posedge hclk);
    report_and_stop();
  end
endmodule : albe_tb_top
